//--- cspg_top.v
`include "cspg_defs.vh"
module cspg_top #(
	parameter CW = 10,
	parameter INVERT_OUT = 1'b0
) (
	// Clock and reset
	input wire clk_i,
	input wire sys_rst_i,
	// Register port
	input wire [15:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [7:0] reg_rdata_o,
	// Analog comparator outputs (asynchronous)
	input wire sync_comparator_i,
	input wire cmp_two_i,
	input wire overcurrent_comparator_i,
	input wire gating_comparator_i,
	input wire surge_i,
	// Pulse output pin
	output reg pulse_out_pin_o,
	output reg pulse_out_pin_oe_o,
	// Surge interrupt request level
	output reg surge_irq_o
);

// ----------------------------------------------------------------
// Comparator synchronisers
// ----------------------------------------------------------------
wire [4:0] cmp_raw;
wire [4:0] cmp_s;
assign cmp_raw = {surge_i, gating_comparator_i, overcurrent_comparator_i,
	cmp_two_i, sync_comparator_i};

genvar gi;
generate
	for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
		// Each comparator cleaned before edge or level use
		cspg_sync u_sync (
			.clk_i(clk_i),
			.sys_rst_i(sys_rst_i),
			.async_i(cmp_raw[gi]),
			.level_o(cmp_s[gi])
		);
	end
endgenerate

// Named views of the clean comparator levels
wire sync_cmp = cmp_s[0];
wire cmp_two = cmp_s[1];
wire ovc_cmp = cmp_s[2];
wire gate_cmp = cmp_s[3];
wire surge_cmp = cmp_s[4];

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
reg [7:0] ctrl_one_q; // Control register one
reg [7:0] ctrl_two_q; // Control register two
reg [7:0] dly_lo_q; // Start delay low byte
reg [1:0] dly_hi_q; // Start delay upper bits
reg [7:0] ea_lo_q; // End A low byte
reg [1:0] ea_hi_q; // End A upper bits
reg [7:0] eb_lo_q; // End B low byte
reg [1:0] eb_hi_q; // End B upper bits

// Control field views
wire op_en = ctrl_one_q[`CSPG_BIT_OP_EN];
wire run = ctrl_one_q[`CSPG_BIT_RUN];
wire repeat_mode = ctrl_one_q[`CSPG_BIT_REPEAT];
wire surge_en = ctrl_one_q[`CSPG_BIT_SURGE_EN];
wire end_sel = ctrl_one_q[`CSPG_BIT_END_SEL];
wire surge_ien = ctrl_one_q[`CSPG_BIT_SURGE_IEN];
wire gate_en = ctrl_two_q[`CSPG_BIT_GATING_COMPARATOR_GATE];

// Write decode strobes
wire wr_c1 = reg_wr_i && (reg_addr_i == `CSPG_ADDR_CTRL_ONE);

// ----------------------------------------------------------------
// Edge detection on synchronised comparators
// ----------------------------------------------------------------
reg sync_cmp_q; // Previous sync comparator level
reg cmp_two_q; // Previous comparator two level
reg surge_q; // Previous surge level
reg run_q; // Previous run bit

// History flops for edge detection
always @(posedge clk_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		sync_cmp_q <= 1'b0;
		cmp_two_q <= 1'b0;
		surge_q <= 1'b0;
		run_q <= 1'b0;
	end else begin
		sync_cmp_q <= sync_cmp;
		cmp_two_q <= cmp_two;
		surge_q <= surge_cmp;
		run_q <= run;
	end
end

// Falling edge seen in the same cycle the clean level drops
wire sync_fall = sync_cmp_q && !sync_cmp;
wire cmp_two_rise = cmp_two && !cmp_two_q;
wire surge_rise = surge_cmp && !surge_q;
wire run_start = run && !run_q;

// Repeat mode latched at run start; later changes have no effect
reg repeat_q;
always @(posedge clk_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		repeat_q <= 1'b0;
	end else if (run_start) begin
		repeat_q <= repeat_mode;
	end
end

// Sync flag: start of run, plus comparator falls in repeat mode
wire sync_flag = run_start ||
	(run && run_q && repeat_q && sync_fall);

// Surge and comparator-two events count only while operating
wire surge_evt = surge_rise && surge_en && op_en;
wire cmp_two_evt = cmp_two_rise && op_en;

// ----------------------------------------------------------------
// Control register one: software writes plus hardware events
// ----------------------------------------------------------------
reg hist_seen_q; // Comparator two seen since last sync fall
always @(posedge clk_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		ctrl_one_q <= `CSPG_RST_BYTE;
		hist_seen_q <= 1'b0;
	end else begin
		if (wr_c1) begin
			ctrl_one_q <= reg_wdata_i;
			// Surge flag: software may only clear it
			ctrl_one_q[`CSPG_BIT_SURGE_FLAG] <=
				ctrl_one_q[`CSPG_BIT_SURGE_FLAG] &
				reg_wdata_i[`CSPG_BIT_SURGE_FLAG];
			// History is read-only, kept by hardware
			ctrl_one_q[`CSPG_BIT_CMP2_HIST] <=
				ctrl_one_q[`CSPG_BIT_CMP2_HIST];
		end
		// Hardware events after the write so they win over a same-cycle write
		if (surge_evt) begin
			ctrl_one_q[`CSPG_BIT_RUN] <= 1'b0;
			ctrl_one_q[`CSPG_BIT_SURGE_FLAG] <= 1'b1;
		end
		if (cmp_two_evt) begin
			ctrl_one_q[`CSPG_BIT_END_SEL] <= 1'b1;
		end
		// History window runs fall to fall while operating
		if (op_en && sync_fall) begin
			ctrl_one_q[`CSPG_BIT_CMP2_HIST] <= hist_seen_q || cmp_two_evt;
			hist_seen_q <= 1'b0;
		end else if (cmp_two_evt) begin
			hist_seen_q <= 1'b1;
		end
	end
end

// ----------------------------------------------------------------
// Other registers
// ----------------------------------------------------------------
always @(posedge clk_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		ctrl_two_q <= `CSPG_RST_BYTE;
		dly_lo_q <= `CSPG_RST_BYTE;
		dly_hi_q <= `CSPG_RST_HIGH;
		ea_lo_q <= `CSPG_RST_BYTE;
		ea_hi_q <= `CSPG_RST_HIGH;
		eb_lo_q <= `CSPG_RST_BYTE;
		eb_hi_q <= `CSPG_RST_HIGH;
	end else if (reg_wr_i) begin
		case (reg_addr_i)
			`CSPG_ADDR_CTRL_TWO: begin
				ctrl_two_q <= reg_wdata_i;
			end
			`CSPG_ADDR_DLY_LO: begin
				dly_lo_q <= reg_wdata_i;
			end
			// High bytes keep only bits 1 and 0
			`CSPG_ADDR_DLY_HI: begin
				dly_hi_q <= reg_wdata_i[1:0];
			end
			`CSPG_ADDR_EA_LO: begin
				ea_lo_q <= reg_wdata_i;
			end
			`CSPG_ADDR_EA_HI: begin
				ea_hi_q <= reg_wdata_i[1:0];
			end
			`CSPG_ADDR_EB_LO: begin
				eb_lo_q <= reg_wdata_i;
			end
			`CSPG_ADDR_EB_HI: begin
				eb_hi_q <= reg_wdata_i[1:0];
			end
			default: begin
				ctrl_two_q <= ctrl_two_q;
			end
		endcase
	end
end

// Read mux; unused high bits read as ones, unmapped reads zero
reg [7:0] rd_d;
always @* begin
	case (reg_addr_i)
		`CSPG_ADDR_CTRL_ONE: rd_d = ctrl_one_q;
		`CSPG_ADDR_CTRL_TWO: rd_d = ctrl_two_q;
		`CSPG_ADDR_DLY_LO: rd_d = dly_lo_q;
		`CSPG_ADDR_DLY_HI: rd_d = {`CSPG_HIGH_FILL, dly_hi_q};
		`CSPG_ADDR_EA_LO: rd_d = ea_lo_q;
		`CSPG_ADDR_EA_HI: rd_d = {`CSPG_HIGH_FILL, ea_hi_q};
		`CSPG_ADDR_EB_LO: rd_d = eb_lo_q;
		`CSPG_ADDR_EB_HI: rd_d = {`CSPG_HIGH_FILL, eb_hi_q};
		default: rd_d = 8'h00;
	endcase
end

// Read data stands only in the cycle after the strobe
always @(posedge clk_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		reg_rdata_o <= 8'h00;
	end else if (reg_rd_i) begin
		reg_rdata_o <= rd_d;
	end else begin
		reg_rdata_o <= 8'h00;
	end
end

// ----------------------------------------------------------------
// Pulse counter
// ----------------------------------------------------------------
reg [CW-1:0] count_q;
always @(posedge clk_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		count_q <= {CW{1'b0}};
	end else if (sync_flag) begin
		count_q <= {CW{1'b0}};
	end else if (run) begin
		count_q <= count_q + {{(CW-1){1'b0}}, 1'b1};
	end
end

// ----------------------------------------------------------------
// Match buffers
// ----------------------------------------------------------------
wire start_hit;
wire end_hit;
wire [CW-1:0] end_setting = end_sel ? {eb_hi_q, eb_lo_q} :
	{ea_hi_q, ea_lo_q};

cspg_match #(.CW(CW)) u_start (
	.clk_i(clk_i),
	.sys_rst_i(sys_rst_i),
	.load_i(sync_flag),
	.setting_i({dly_hi_q, dly_lo_q}),
	.count_i(count_q),
	.hit_o(start_hit)
);

cspg_match #(.CW(CW)) u_end (
	.clk_i(clk_i),
	.sys_rst_i(sys_rst_i),
	.load_i(sync_flag),
	.setting_i(end_setting),
	.count_i(count_q),
	.hit_o(end_hit)
);

// ----------------------------------------------------------------
// Overcurrent blanking after each period start
// ----------------------------------------------------------------
// Full-width count cut to the blanking counter width on purpose
localparam integer BLANK_FULL = `CSPG_BLANK_CYCLES;
localparam [7:0] BLANK_CYC = BLANK_FULL[7:0];
reg [7:0] blank_q;
always @(posedge clk_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		blank_q <= 8'h00;
	end else if (sync_flag) begin
		blank_q <= BLANK_CYC;
	end else if (blank_q != 8'h00) begin
		blank_q <= blank_q - 8'h01;
	end
end
wire ovc_clear = ovc_cmp && (blank_q == 8'h00);

// ----------------------------------------------------------------
// Pulse output state
// ----------------------------------------------------------------
// Gate passes when disabled or gating comparator low
wire gate_ok = !gate_en || !gate_cmp;
reg pulse_q;
always @(posedge clk_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		pulse_q <= 1'b0;
	end else if (!run) begin
		pulse_q <= 1'b0;
	end else if (ovc_clear) begin
		pulse_q <= 1'b0;
	end else if (end_hit && !sync_flag) begin
		pulse_q <= 1'b0;
	end else if (start_hit && !sync_flag && gate_ok) begin
		pulse_q <= 1'b1;
	end
end

// Pin driver, polarity option, interrupt level
always @(posedge clk_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		pulse_out_pin_o <= 1'b0;
		pulse_out_pin_oe_o <= 1'b0;
		surge_irq_o <= 1'b0;
	end else begin
		// Gating applied live so the pin drops as soon as gate closes
		pulse_out_pin_o <= (pulse_q && gate_ok) ^ INVERT_OUT;
		pulse_out_pin_oe_o <= op_en;
		surge_irq_o <= surge_ien && ctrl_one_q[`CSPG_BIT_SURGE_FLAG];
	end
end

endmodule // cspg_top

//--- cspg_defs.vh
`ifndef CSPG_DEFS_VH
`define CSPG_DEFS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses on the 16-bit register port)
// ----------------------------------------------------------------
`define CSPG_ADDR_CTRL_ONE 16'hFE90
`define CSPG_ADDR_CTRL_TWO 16'hFE91
`define CSPG_ADDR_DLY_LO 16'hFE92
`define CSPG_ADDR_DLY_HI 16'hFE93
`define CSPG_ADDR_EA_LO 16'hFE94
`define CSPG_ADDR_EA_HI 16'hFE95
`define CSPG_ADDR_EB_LO 16'hFE96
`define CSPG_ADDR_EB_HI 16'hFE97

// ----------------------------------------------------------------
// Control register one fields
// ----------------------------------------------------------------
`define CSPG_BIT_OP_EN 7
`define CSPG_BIT_RUN 6
`define CSPG_BIT_REPEAT 5
`define CSPG_BIT_SURGE_EN 4
`define CSPG_BIT_END_SEL 3
`define CSPG_BIT_CMP2_HIST 2
`define CSPG_BIT_SURGE_FLAG 1
`define CSPG_BIT_SURGE_IEN 0

// ----------------------------------------------------------------
// Control register two fields
// ----------------------------------------------------------------
`define CSPG_BIT_GATING_COMPARATOR_GATE 3

// ----------------------------------------------------------------
// Reset values and read fill for unused high bits
// ----------------------------------------------------------------
`define CSPG_RST_BYTE 8'h00
`define CSPG_RST_HIGH 2'h0
`define CSPG_HIGH_FILL 6'h3F

// ----------------------------------------------------------------
// Timing: blanking of the overcurrent comparator, in half periods
// ----------------------------------------------------------------
`define CSPG_BLANK_HALF_PERIODS 191
// 95.5 periods rounded up to whole clock cycles
`define CSPG_BLANK_CYCLES ((`CSPG_BLANK_HALF_PERIODS + 1) / 2)

`endif

//--- cspg_sync.v
// ----------------------------------------------------------------
// Three-flop synchroniser with agreement check
// ----------------------------------------------------------------
module cspg_sync (
	// Clock and reset
	input wire clk_i,
	input wire sys_rst_i,
	// Asynchronous level in, clean level out
	input wire async_i,
	output reg level_o
);

// Stage flops; first one is read only by the second
reg meta_q;
reg mid_q;
reg last_q;

// Change accepted once stages two and three agree
always @(posedge clk_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		meta_q <= 1'b0;
		mid_q <= 1'b0;
		last_q <= 1'b0;
		level_o <= 1'b0;
	end else begin
		meta_q <= async_i;
		mid_q <= meta_q;
		last_q <= mid_q;
		if (mid_q == last_q) begin
			level_o <= last_q;
		end
	end
end

endmodule // cspg_sync

//--- cspg_match.v
`include "cspg_defs.vh"
// ----------------------------------------------------------------
// Match buffer: reloads on sync flag, compares against counter
// ----------------------------------------------------------------
module cspg_match #(
	parameter CW = 10
) (
	// Clock and reset
	input wire clk_i,
	input wire sys_rst_i,
	// Reload control and data
	input wire load_i,
	input wire [CW-1:0] setting_i,
	// Live counter
	input wire [CW-1:0] count_i,
	// Equality flag
	output wire hit_o
);

// Match buffer
reg [CW-1:0] buf_q;

// Reload only on sync, so setting writes mid-period wait
always @(posedge clk_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		buf_q <= {CW{1'b0}};
	end else if (load_i) begin
		buf_q <= setting_i;
	end
end

// Flag while buffer equals counter
assign hit_o = (buf_q == count_i);

endmodule // cspg_match

//--- cspg_top_monitor.sv
`include "cspg_defs.vh"
// ----------------------------------------------------------------
// Port checker for the pulse generator
// ----------------------------------------------------------------
module cspg_chk #(
	parameter CW = 10,
	parameter INVERT_OUT = 1'b0
) (
	// Clock and reset
	input wire clk_i,
	input wire sys_rst_i,
	// Register port
	input wire [15:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	input wire [7:0] reg_rdata_o,
	// Comparators and pin
	input wire overcurrent_comparator_i,
	input wire gating_comparator_i,
	input wire surge_i,
	input wire pulse_out_pin_o,
	input wire pulse_out_pin_oe_o,
	input wire surge_irq_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------------------
	// Shadow copies of software-written bits
	// ------------------------------------------------------------
	wire wr_one = reg_wr_i && reg_addr_i == `CSPG_ADDR_CTRL_ONE;
	wire idle_pin = pulse_out_pin_o == INVERT_OUT; // Inactive level
	logic op_en_q, op_en_p, ien_q, sen_q, gate_en_q;
	logic [7:0] age_q; // Cycles since last control register one write, saturating
	// Track only what software wrote; surge effects are not mirrored
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			op_en_q <= 1'b0;
			op_en_p <= 1'b0;
			ien_q <= 1'b0;
			sen_q <= 1'b0;
			gate_en_q <= 1'b0;
			age_q <= 8'h00;
		end else begin
			op_en_p <= op_en_q;
			if (wr_one) begin
				op_en_q <= reg_wdata_i[7];
				sen_q <= reg_wdata_i[4];
				ien_q <= reg_wdata_i[0];
			end
			if (reg_wr_i && reg_addr_i == `CSPG_ADDR_CTRL_TWO)
				gate_en_q <= reg_wdata_i[3];
			age_q <= wr_one ? 8'h00 : (age_q == 8'hFF ? age_q : age_q + 8'h01);
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	rd_idle_a: assert property (
		!$past(reg_rd_i) |-> reg_rdata_o == 8'h00) else $error("read data outside slot");
	unmapped_rd_a: assert property (
		reg_rd_i && (reg_addr_i < 16'hFE90 || reg_addr_i > 16'hFE97)
		|=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
	high_fill_a: assert property (
		reg_rd_i && reg_addr_i[0] && reg_addr_i >= 16'hFE93 && reg_addr_i <= 16'hFE97
		|=> reg_rdata_o[7:2] == 6'h3F) else $error("high byte fill wrong");
	oe_follow_a: assert property (
		op_en_q == op_en_p |-> pulse_out_pin_oe_o == op_en_q) else $error("pin enable wrong");
	run_off_a: assert property (
		wr_one && !reg_wdata_i[6] |-> ##[1:4] idle_pin) else $error("run off kept pulse");
	// Only once the 96-cycle blanking after a run start is surely over
	over_clear_a: assert property (
		$rose(overcurrent_comparator_i) && age_q > 8'h60 |-> ##[1:10] idle_pin)
		else $error("overcurrent did not clear");
	gate_block_a: assert property (
		(gate_en_q && gating_comparator_i) [*8] |-> idle_pin) else $error("gate ignored");
	surge_stop_a: assert property (
		$rose(surge_i) && op_en_q && sen_q |-> ##[1:10] idle_pin) else $error("surge ignored");
	irq_enable_a: assert property (
		surge_irq_o |-> $past(ien_q)) else $error("irq without enable");
	// Main scenarios reached
	cover property ($rose(pulse_out_pin_o));
	cover property ($rose(surge_irq_o));
	cover property ((gate_en_q && gating_comparator_i) [*8]);
endmodule // cspg_chk

bind cspg_top cspg_chk #(.CW(CW), .INVERT_OUT(INVERT_OUT)) u_chk (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o),
	.overcurrent_comparator_i(overcurrent_comparator_i),
	.gating_comparator_i(gating_comparator_i), .surge_i(surge_i),
	.pulse_out_pin_o(pulse_out_pin_o),
	.pulse_out_pin_oe_o(pulse_out_pin_oe_o), .surge_irq_o(surge_irq_o));

//--- comparator_synced_pulse_generator_bench.sv
`include "cspg_defs.vh"
module comparator_synced_pulse_generator_bench;
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------------------
	// Stimulus, observation and bookkeeping
	// ------------------------------------------------------------
	logic clk_i = 0, sys_rst_i = 1, wr = 0, rd = 0, rd_d = 0, wchk = 1;
	logic sync_comparator = 1, cmp2 = 0, oc = 0, gate = 0, surge = 0;
	logic oe_x = 0, irq_x = 0; // Expected pin enable and interrupt level
	logic [15:0] addr = 16'h0000;
	logic [7:0] wdata = 8'h00, d;
	logic [15:0] hi_n = 16'h0000; // Cycles the pin has been high
	logic [15:0] rq[$], wq[$]; // Expected read data and pulse widths
	wire [7:0] rdata;
	wire pin, oe, irq;
	int failures = 0, cmp_count = 0, seed = 93, n, s, e;
	cspg_top #(.CW(10), .INVERT_OUT(1'b0)) DUT (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdata), .sync_comparator_i(sync_comparator), .cmp_two_i(cmp2),
		.overcurrent_comparator_i(oc), .gating_comparator_i(gate),
		.surge_i(surge), .pulse_out_pin_o(pin), .pulse_out_pin_oe_o(oe),
		.surge_irq_o(irq));
	// 25 MHz clock
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input [15:0] seen, input [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		if (failures == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic wr_r(input [15:0] a, input [7:0] v);
		@(posedge clk_i);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask
	task automatic rd_r(input [15:0] a, input [7:0] x);
		@(posedge clk_i);
		rq.push_back({6'h00, oe_x, irq_x, x});
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
	endtask
	task automatic idle(input int c);
		repeat (c) @(posedge clk_i);
	endtask
	// Bounded wait until at most k widths are still pending
	task automatic wait_w(input int k);
		for (int i = 0; i < 1100 && wq.size() > k; i++) @(posedge clk_i);
		if (wq.size() > k) begin
			failures++;
			give_verdict;
		end
	endtask
	// One pulse period, two in repeat mode; the unused end setting is a decoy
	task automatic pulse(input int s, input int e, input bit sel, input bit rep);
		int ea = sel ? e + 7 : e;
		int eb = sel ? e : e + 7;
		wr_r(`CSPG_ADDR_DLY_LO, s[7:0]);
		wr_r(`CSPG_ADDR_DLY_HI, {6'h00, s[9:8]});
		wr_r(`CSPG_ADDR_EA_LO, ea[7:0]);
		wr_r(`CSPG_ADDR_EA_HI, {6'h00, ea[9:8]});
		wr_r(`CSPG_ADDR_EB_LO, eb[7:0]);
		wr_r(`CSPG_ADDR_EB_HI, {6'h00, eb[9:8]});
		wq.push_back(16'(e - s));
		if (rep) wq.push_back(16'(e - s));
		wr_r(`CSPG_ADDR_CTRL_ONE, {2'b11, rep, 1'b0, sel, 3'b000});
		wait_w(rep);
		// Falling sync comparator restarts the period
		if (rep) begin
			sync_comparator <= 1'b0;
			wait_w(0);
			sync_comparator <= 1'b1;
		end
		wr_r(`CSPG_ADDR_CTRL_ONE, 8'h80); // Stop before the counter wraps
		idle(4);
	endtask
	// ------------------------------------------------------------
	// Watcher: read data and pulse widths against the notes
	// ------------------------------------------------------------
	always @(posedge clk_i) begin
		rd_d <= rd;
		if (rd_d) chk({6'h00, oe, irq, rdata}, rq.pop_front());
		if (pin === 1'b1) hi_n <= hi_n + 16'h0001;
		else if (hi_n != 16'h0000) begin
			if (wchk) chk(hi_n, wq.size() ? wq.pop_front() : 16'hFFFF);
			hi_n <= 16'h0000;
		end
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		idle(8);
		sys_rst_i <= 1'b0;
		for (n = 0; n < 8; n++)
			rd_r(16'hFE90 + n, (n > 2 && n[0]) ? 8'hFC : 8'h00);
		rd_r(16'hFE98, 8'h00);
		rd_r(16'hFE8F, 8'h00);
		for (n = 1; n < 8; n++) begin
			d = 8'($random(seed));
			wr_r(16'hFE90 + n, d);
			rd_r(16'hFE90 + n, (n > 2 && n[0]) ? {6'h3F, d[1:0]} : d);
		end
		wr_r(`CSPG_ADDR_CTRL_TWO, 8'h00);
		// Status bits cannot be set by software
		wr_r(`CSPG_ADDR_CTRL_ONE, 8'h06);
		rd_r(`CSPG_ADDR_CTRL_ONE, 8'h00);
		wr_r(`CSPG_ADDR_CTRL_ONE, 8'h80);
		oe_x = 1'b1;
		cmp2 <= 1'b1;
		idle(10);
		rd_r(`CSPG_ADDR_CTRL_ONE, 8'h88);
		cmp2 <= 1'b0;
		// Surge stops the run and latches the flag
		wchk <= 1'b0;
		wr_r(`CSPG_ADDR_CTRL_ONE, 8'hD1);
		surge <= 1'b1;
		idle(10);
		irq_x = 1'b1;
		rd_r(`CSPG_ADDR_CTRL_ONE, 8'h93);
		wr_r(`CSPG_ADDR_CTRL_ONE, 8'h91);
		irq_x = 1'b0;
		rd_r(`CSPG_ADDR_CTRL_ONE, 8'h91);
		surge <= 1'b0;
		idle(4);
		wchk <= 1'b1;
		// Widths with high bits, then random A/B and one-shot/repeat
		pulse(10'h105, 10'h203, 1'b0, 1'b0);
		for (n = 0; n < 4; n++) begin
			s = 2 + ($random(seed) & 31);
			e = s + 2 + ($random(seed) & 63);
			pulse(s, e, n[0], n[1]);
		end
		// Overcurrent inside the blanking window is ignored
		oc <= 1'b1;
		fork
			pulse(5, 40, 1'b0, 1'b0);
			begin
				idle(44);
				oc <= 1'b0;
			end
		join
		// Overcurrent after blanking cuts a long pulse: start 5, end 511
		wr_r(`CSPG_ADDR_EA_LO, 8'hFF);
		wr_r(`CSPG_ADDR_EA_HI, 8'h01);
		// Rise 100 cycles after run, four sync stages, two output stages
		wq.push_back(16'h0062);
		wr_r(`CSPG_ADDR_CTRL_ONE, 8'hC0);
		idle(100);
		oc <= 1'b1;
		idle(12);
		oc <= 1'b0;
		wait_w(0);
		// Gating comparator holds the output off from a fresh start
		wr_r(`CSPG_ADDR_CTRL_ONE, 8'h80);
		wr_r(`CSPG_ADDR_CTRL_TWO, 8'h08);
		gate <= 1'b1;
		idle(8);
		wr_r(`CSPG_ADDR_CTRL_ONE, 8'hC0);
		idle(100);
		wr_r(`CSPG_ADDR_CTRL_ONE, 8'h00);
		gate <= 1'b0;
		idle(8);
		give_verdict;
	end
endmodule // comparator_synced_pulse_generator_bench
